/* File: common/sclk_pkg.sv */
package sclk_pkg;
   // Bus clock and the reset hold time
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_HOLD_NS = 100_000;
   // Least time, so it rounds up to whole cycles
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Mask layout
   localparam int MASK_W = 16;
   localparam int MASK_IDX_W = 4;
   localparam int NUM_CLK = 10;
   localparam int PAIR_CLKS = 4;
   localparam int SINGLE_BASE = 8;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   // Bus cycles per shift phase, and per half period of the primary clock
   localparam int SHIFT_DIV = 4;
   localparam int PCLK_HALF = 1;
   // General-purpose pins
   localparam int GPIO_W = 4;
   localparam int PIN_SHIFT = 0;
   localparam int PIN_LOAD = 2;
   localparam logic [3:0] GPIO_RESET = 4'h0;
   // Register byte offsets
   localparam logic [7:0] OFF_CLK_MASK = 8'h00;
   localparam logic [7:0] OFF_BRIDGE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_GPIO_OUT = 8'h0c;
   localparam logic [7:0] OFF_GPIO_OE = 8'h10;
   localparam logic [7:0] OFF_GPIO_IN = 8'h14;
   // Field positions
   localparam int SEC_RST_BIT = 6;
   localparam int CLR_FIELD_LSB = 8;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sclk_pkg

/* File: common/mask_load_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Link between the control block and the mask shift sequencer
interface mask_load_if;
   logic run; // Level: primary reset released
   logic busy; // Load or shift under way
   logic done; // All mask bits taken
   logic bit_we; // One-cycle pulse: store bit_val at bit_idx
   logic [3:0] bit_idx;
   logic bit_val;
   logic load_pin; // Parallel load control, low to load
   logic shift_pin; // Shift control, rising edge shifts
   modport ctrl(output run, input busy, done, bit_we, bit_idx, bit_val, load_pin, shift_pin);
   modport seq(input run, output busy, done, bit_we, bit_idx, bit_val, load_pin, shift_pin);
endinterface : mask_load_if
`default_nettype wire

/* File: hdl/mask_shifter.sv */
`timescale 1ns/1ns
`default_nettype none
module mask_shifter #(
   parameter int SHIFT_DIV = sclk_pkg::SHIFT_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic serial_mask_input,
   mask_load_if.seq lk
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CLOCK = 3'b011,
      ST_DONE = 3'b100
   } shift_state_e;

   shift_state_e state_reg, state_next;
   logic [7:0] div_reg, div_next; // Phase timer
   logic [3:0] idx_reg, idx_next; // Bit being taken
   wire tick = (div_reg == 8'(SHIFT_DIV - 1));
   wire last_bit = (idx_reg == 4'(sclk_pkg::MASK_W - 1));

   // Pins and strobes decoded from the state
   assign lk.busy = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
   assign lk.done = (state_reg == ST_DONE);
   assign lk.load_pin = (state_reg != ST_LOAD);
   assign lk.shift_pin = (state_reg == ST_CLOCK);
   assign lk.bit_we = (state_reg == ST_SAMPLE) && tick;
   assign lk.bit_idx = idx_reg;
   assign lk.bit_val = serial_mask_input;
   assign div_next = (!lk.busy || tick) ? 8'h00 : div_reg + 8'h01;

   // Load once, then sample and clock each bit from bit 0 up
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      unique case (state_reg)
         ST_IDLE: begin
            idx_next = 4'h0;
            if (lk.run) state_next = ST_LOAD;
         end
         ST_LOAD: if (tick) state_next = ST_SAMPLE;
         ST_SAMPLE: if (tick) state_next = ST_CLOCK;
         ST_CLOCK: begin
            if (tick) begin
               state_next = last_bit ? ST_DONE : ST_SAMPLE;
               idx_next = last_bit ? idx_reg : idx_reg + 4'h1;
            end
         end
         ST_DONE: state_next = ST_DONE;
         default: state_next = ST_IDLE;
      endcase
      // Primary reset again aborts and restarts
      if (!lk.run) state_next = ST_IDLE;
   end

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         div_reg <= 8'h00;
         idx_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         idx_reg <= idx_next;
      end
   end
endmodule : mask_shifter
`default_nettype wire

/* File: hdl/sec_clk_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module sec_clk_gen #(
   parameter int NUM_CLK = sclk_pkg::NUM_CLK,
   parameter int PCLK_HALF = sclk_pkg::PCLK_HALF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic halve,
   input wire logic [NUM_CLK-1:0] mask_off,
   output logic [NUM_CLK-1:0] clk_out
);
   logic [7:0] div_reg; // Primary clock half-period timer
   logic pclk_reg; // Primary clock phase
   logic half_reg; // Primary clock divided by two
   wire tick = run && (div_reg == 8'(PCLK_HALF - 1));
   wire pclk_next = tick ? ~pclk_reg : pclk_reg;
   wire half_next = (tick && !pclk_reg) ? ~half_reg : half_reg;
   // Halved only for a fast primary with a slow secondary
   wire src_next = halve ? half_next : pclk_next;

   // Phase generator; any rate up to the divider's limit
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         div_reg <= 8'h00;
         pclk_reg <= 1'b0;
         half_reg <= 1'b0;
      end else begin
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
         pclk_reg <= pclk_next;
         half_reg <= half_next;
      end
   end

   // Same edge as the phase flop keeps outputs in phase
   for (genvar i = 0; i < NUM_CLK; i++) begin : g_out
      always_ff @(posedge aclk) begin
         if (!aresetn || !run) clk_out[i] <= 1'b0; // Stopped
         else clk_out[i] <= mask_off[i] | src_next; // Masked sits high
      end
   end

   masked_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && mask_off[0] ##1 run |-> clk_out[0])
      else $error("masked clock not held high");
   in_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && !halve && !mask_off[1] |=> clk_out[1] == pclk_reg)
      else $error("clock not in phase with primary");
   stopped_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !run |=> clk_out == '0)
      else $error("clock runs during primary reset");
endmodule : sec_clk_gen
`default_nettype wire

/* File: hdl/sec_clock_ctrl.sv */
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module sec_clock_ctrl #(
   parameter int HOLD_CYCLES = sclk_pkg::RST_HOLD_CYC,
   parameter int SHIFT_DIV = sclk_pkg::SHIFT_DIV,
   parameter int PCLK_HALF = sclk_pkg::PCLK_HALF
) (
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Bridge pins
   input wire logic primary_reset_n,
   input wire logic primary_fast_enable,
   input wire logic secondary_fast_enable,
   input wire logic serial_mask_input,
   output logic secondary_reset_n,
   output logic [9:0] secondary_clock_out,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe
);
   localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] mask_reg, mask_next; // Clock disable mask
   logic sec_rst_reg; // Software secondary reset bit
   logic [3:0] gpio_dat_reg, gpio_dat_next; // Output data field
   logic [3:0] gpio_en_reg, gpio_en_next; // Output enable field
   logic [HOLD_W-1:0] hold_cnt_reg; // Reset hold timer
   logic bvalid_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [9:0] clk_off; // Per-output disable
   mask_load_if lk();

   ////////////////////////////////////////////////////////////////////////////
   // Mask shift sequencer
   ////////////////////////////////////////////////////////////////////////////
   // Runs as soon as primary reset is gone; secondary reset is then held
   assign lk.run = primary_reset_n;

   mask_shifter #(
      .SHIFT_DIV(SHIFT_DIV)
   ) u_shifter (
      .aclk(aclk),
      .aresetn(aresetn),
      .serial_mask_input(serial_mask_input),
      .lk(lk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write channel decode
   ////////////////////////////////////////////////////////////////////////////
   // Both halves taken together, only with no response pending
   wire wr_go = awvalid && wvalid && !bvalid_reg;
   wire wr_mask = wr_go && (awaddr == sclk_pkg::OFF_CLK_MASK);
   wire wr_bridge = wr_go && (awaddr == sclk_pkg::OFF_BRIDGE);
   wire wr_gout = wr_go && (awaddr == sclk_pkg::OFF_GPIO_OUT);
   wire wr_goe = wr_go && (awaddr == sclk_pkg::OFF_GPIO_OE);
   // Read-only offsets still answer OKAY; the write is dropped
   wire wr_ro = (awaddr == sclk_pkg::OFF_STATUS) || (awaddr == sclk_pkg::OFF_GPIO_IN);
   wire wr_known = wr_mask || wr_bridge || wr_gout || wr_goe || (wr_go && wr_ro);
   wire [7:0] set_f = wdata[7:0] & {8{wstrb[0]}};
   wire [7:0] clr_f = wdata[15:8] & {8{wstrb[1]}};
   assign awready = wr_go;
   assign wready = wr_go;

   ////////////////////////////////////////////////////////////////////////////
   // Mask register next value
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      mask_next = mask_reg;
      // Software rewrite at any time, by byte lane
      if (wr_mask) begin
         if (wstrb[0]) mask_next[7:0] = wdata[7:0];
         if (wstrb[1]) mask_next[15:8] = wdata[15:8];
      end
      // A shifted bit wins over a software write in the same cycle
      if (lk.bit_we) mask_next[lk.bit_idx] = lk.bit_val;
   end

   // General-purpose fields: write one to set, write one to clear
   assign gpio_dat_next = wr_gout ? (gpio_dat_reg | set_f[3:0]) & ~clr_f[3:0] : gpio_dat_reg;
   assign gpio_en_next = wr_goe ? (gpio_en_reg | set_f[3:0]) & ~clr_f[3:0] : gpio_en_reg;

   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_reg <= sclk_pkg::MASK_RESET;
         sec_rst_reg <= 1'b0;
         gpio_dat_reg <= sclk_pkg::GPIO_RESET;
         gpio_en_reg <= sclk_pkg::GPIO_RESET;
      end else begin
         mask_reg <= mask_next;
         if (wr_bridge && wstrb[0]) sec_rst_reg <= wdata[sclk_pkg::SEC_RST_BIT];
         gpio_dat_reg <= gpio_dat_next;
         gpio_en_reg <= gpio_en_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Secondary reset sequencing
   ////////////////////////////////////////////////////////////////////////////
   // Hold timer runs only after the shift and with the bit clear
   wire hold_ok = (hold_cnt_reg == HOLD_W'(HOLD_CYCLES));
   wire hold_clr = !lk.done || sec_rst_reg || !primary_reset_n;
   wire sec_rel_next = primary_reset_n && lk.done && !sec_rst_reg && hold_ok;

   // Timer and reset output; release waits for the bit to clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt_reg <= '0;
         secondary_reset_n <= 1'b0;
      end else begin
         if (hold_clr) hold_cnt_reg <= '0;
         else if (!hold_ok) hold_cnt_reg <= hold_cnt_reg + HOLD_W'(1);
         secondary_reset_n <= sec_rel_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // General-purpose pins
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer owns pins 0 and 2 only while shifting
   wire [3:0] pin_seq_en = 4'((1 << sclk_pkg::PIN_SHIFT) | (1 << sclk_pkg::PIN_LOAD));
   wire [3:0] pin_seq_dat = 4'({3'h0, lk.shift_pin} << sclk_pkg::PIN_SHIFT)
      | 4'({3'h0, lk.load_pin} << sclk_pkg::PIN_LOAD);
   wire [3:0] pin_oe_next = lk.busy ? (gpio_en_reg | pin_seq_en) : gpio_en_reg;
   wire [3:0] pin_dat_next = lk.busy ? (gpio_dat_reg & ~pin_seq_en) | pin_seq_dat
      : gpio_dat_reg;

   // Pin flops keep the pads glitch free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gpio_oe <= 4'h0;
         gpio_out <= 4'h0;
      end else begin
         gpio_oe <= pin_oe_next;
         gpio_out <= pin_dat_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Secondary clock outputs
   ////////////////////////////////////////////////////////////////////////////
   // Either bit of a pair disables its output
   for (genvar i = 0; i < sclk_pkg::PAIR_CLKS; i++) begin : g_pair
      assign clk_off[i] = mask_reg[2*i] | mask_reg[2*i+1];
   end
   // Single bits for the rest; top two bits unused
   for (genvar j = sclk_pkg::PAIR_CLKS; j < sclk_pkg::NUM_CLK; j++) begin : g_single
      assign clk_off[j] = mask_reg[sclk_pkg::SINGLE_BASE + j - sclk_pkg::PAIR_CLKS];
   end

   // Halving decided by the two speed pins
   sec_clk_gen #(
      .NUM_CLK(sclk_pkg::NUM_CLK),
      .PCLK_HALF(PCLK_HALF)
   ) u_clk_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(primary_reset_n),
      .halve(primary_fast_enable && !secondary_fast_enable),
      .mask_off(clk_off),
      .clk_out(secondary_clock_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Response channels
   ////////////////////////////////////////////////////////////////////////////
   wire rd_go = arvalid && !rvalid_reg;
   wire [31:0] status_word = {28'h0, hold_ok, lk.busy, secondary_reset_n, lk.done};
   wire rd_known = (araddr == sclk_pkg::OFF_CLK_MASK) || (araddr == sclk_pkg::OFF_BRIDGE)
      || (araddr == sclk_pkg::OFF_STATUS) || (araddr == sclk_pkg::OFF_GPIO_OUT)
      || (araddr == sclk_pkg::OFF_GPIO_OE) || (araddr == sclk_pkg::OFF_GPIO_IN);
   wire [31:0] rd_sel =
      (araddr == sclk_pkg::OFF_CLK_MASK) ? {16'h0, mask_reg} :
      (araddr == sclk_pkg::OFF_BRIDGE) ? 32'(sec_rst_reg) << sclk_pkg::SEC_RST_BIT :
      (araddr == sclk_pkg::OFF_STATUS) ? status_word :
      (araddr == sclk_pkg::OFF_GPIO_OUT) ? {28'h0, gpio_dat_reg} :
      (araddr == sclk_pkg::OFF_GPIO_OE) ? {28'h0, gpio_en_reg} :
      (araddr == sclk_pkg::OFF_GPIO_IN) ? {28'h0, gpio_in} : 32'h0;
   assign arready = !rvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;

   // Write answer one cycle after the take; unmapped gets SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= sclk_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_known ? sclk_pkg::RESP_OKAY : sclk_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read answer one cycle after the take; unmapped reads zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= sclk_pkg::RESP_OKAY;
         rdata_reg <= 32'h0;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_known ? sclk_pkg::RESP_OKAY : sclk_pkg::RESP_SLVERR;
         rdata_reg <= rd_sel;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////////
   shift_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !lk.done |=> !secondary_reset_n)
      else $error("secondary reset released before shift end");
   hold_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(secondary_reset_n) |-> $past(hold_ok) && $past(lk.done))
      else $error("secondary reset released before hold time");
   bit_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sec_rst_reg |=> !secondary_reset_n)
      else $error("reset bit did not hold secondary reset");
   shift_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(primary_reset_n) |-> ##[1:2] lk.busy)
      else $error("mask shift did not start");
   shift_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      lk.bit_we |=> mask_reg[$past(lk.bit_idx)] == $past(lk.bit_val))
      else $error("shifted bit not stored");
   mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_mask && wstrb[1:0] == 2'h3 && !lk.bit_we |=> mask_reg == $past(wdata[15:0]))
      else $error("mask write not applied");
   pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
      lk.busy |=> gpio_oe[sclk_pkg::PIN_SHIFT] && gpio_oe[sclk_pkg::PIN_LOAD])
      else $error("shift control pins not driven");
   pin_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
      lk.done |=> gpio_oe == $past(gpio_en_reg))
      else $error("pins not returned after shift");
endmodule : sec_clock_ctrl
`default_nettype wire

/* File: tb/mask_source.sv */
`timescale 1ns/1ns
`default_nettype none
// Board shift register that feeds the clock mask, or a plain tie when not fitted
module mask_source (
   input wire logic load_pin, // Low loads the parallel word
   input wire logic shift_pin, // Rising edge moves one bit out
   input wire logic fitted, // Register present on the board
   input wire logic tie_level, // Level of the serial line with no register
   input wire logic [15:0] word, // Parallel word held on the board
   output logic serial_out
);
   logic [15:0] sr_reg = 16'h5a5a; // Shift stage, junk until first load
   //////////////////////////////////////////////////////////////////////
   // Load is level sensitive; the inverted refill keeps stale bits moving
   always @(posedge shift_pin or negedge load_pin) begin
      if (!load_pin) begin
         sr_reg <= word;
      end else begin
         sr_reg <= {~sr_reg[0], sr_reg[15:1]};
      end
   end
   // Bit 0 leaves first
   assign serial_out = fitted ? sr_reg[0] : tie_level;
endmodule : mask_source
`default_nettype wire

/* File: tb/tb_secondary_clock_mask_and_outputs.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_secondary_clock_mask_and_outputs;
   localparam int HOLD = 20; // Short hold keeps the run brief
   localparam int SDIV = 2;
   localparam int SHIFT_CYC = SDIV * 33; // Load phase plus two phases per bit
   logic aclk, aresetn;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, gpio_in, gpio_out, gpio_oe;
   logic [1:0] bresp, rresp, exp_b;
   logic primary_reset_n, primary_fast_enable, secondary_fast_enable, serial_mask_input;
   logic secondary_reset_n;
   logic [9:0] secondary_clock_out;
   logic fitted, tie_level; // Partner mode
   logic [15:0] word, m; // Board word, current mask
   logic [1:0] bq[$]; // Expected write answers
   logic [33:0] rq[$]; // Expected read answers
   logic [33:0] exp_r;
   logic [3:0] oe_seen; // Pins driven during a shift
   int failures, comparisons, cycles, seed, n;
   //////////////////////////////////////////////////////////////////////
   // Released pins are pulled up
   assign gpio_in = (gpio_oe & gpio_out) | ~gpio_oe;
   sec_clock_ctrl #(.HOLD_CYCLES(HOLD), .SHIFT_DIV(SDIV), .PCLK_HALF(1)) dut (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .primary_reset_n,
      .primary_fast_enable, .secondary_fast_enable, .serial_mask_input, .secondary_reset_n,
      .secondary_clock_out, .gpio_in, .gpio_out, .gpio_oe);
   mask_source ext (.load_pin(gpio_in[sclk_pkg::PIN_LOAD]),
      .shift_pin(gpio_in[sclk_pkg::PIN_SHIFT]), .fitted(fitted), .tie_level(tie_level),
      .word(word), .serial_out(serial_mask_input));
   //////////////////////////////////////////////////////////////////////
   // Clock, 10 ns period
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Hang guard, far above the expected few hundred cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   // Oldest note against each bus answer as it is handed over
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
         exp_b = bq.pop_front();
         `CHK(bresp, exp_b)
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
         exp_r = rq.pop_front();
         `CHK({rresp, rdata}, exp_r)
      end
   end
   //////////////////////////////////////////////////////////////////////
   // Write; address and data offered together, extra edge avoids double drive
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_write
   // Read with its expected answer noted first
   task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read
   // Cycles until the secondary reset lets go
   task automatic wait_release(output int c);
      c = 0;
      oe_seen = 4'h0;
      while (secondary_reset_n !== 1'b1 && c < 1000) begin
         @(posedge aclk);
         oe_seen = oe_seen | gpio_oe;
         c++;
      end
   endtask : wait_release
   // Primary reset pulse, then the mask load that follows it
   task automatic boot(input logic fit, input logic tie, input logic [15:0] w,
         input logic [15:0] expm);
      primary_reset_n <= 1'b0;
      fitted <= fit;
      tie_level <= tie;
      word <= w;
      repeat (4) @(posedge aclk);
      `CHK({secondary_reset_n, secondary_clock_out, gpio_oe}, 15'h0)
      primary_reset_n <= 1'b1;
      wait_release(n);
      `CHK((n >= SHIFT_CYC + HOLD) && (n <= SHIFT_CYC + HOLD + 8), 1'b1)
      `CHK({oe_seen, gpio_oe}, 8'h50)
      axi_read(sclk_pkg::OFF_CLK_MASK, {16'h0, expm}, sclk_pkg::RESP_OKAY);
   endtask : boot
   // Toggle count per output over eight cycles; masked outputs sit high
   task automatic check_clocks(input logic [15:0] mk, input logic halve);
      logic [9:0] off;
      logic [9:0] prev;
      int tog [10];
      for (int i = 0; i < 10; i++) begin
         off[i] = (i < 4) ? (mk[2 * i] | mk[2 * i + 1]) : mk[i + 4];
         tog[i] = 0;
      end
      repeat (4) @(posedge aclk);
      prev = secondary_clock_out;
      repeat (8) begin
         @(posedge aclk);
         for (int i = 0; i < 10; i++) tog[i] += int'(secondary_clock_out[i] !== prev[i]);
         prev = secondary_clock_out;
      end
      for (int i = 0; i < 10; i++) `CHK(tog[i], off[i] ? 0 : (halve ? 4 : 8))
      `CHK(prev & off, off)
      `CHK(((prev & ~off) == 10'h0) || ((prev | off) == 10'h3ff), 1'b1)
   endtask : check_clocks
   // Counts, verdict, end of run
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h5cbb;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000f;
      {primary_reset_n, primary_fast_enable, secondary_fast_enable} = 3'h0;
      {fitted, tie_level, word} = 18'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Board register holding a random word
      m = $random(seed);
      boot(1'b1, 1'b0, m, m);
      // Every speed pin combination
      for (int c = 0; c < 4; c++) begin
         primary_fast_enable <= c[1];
         secondary_fast_enable <= c[0];
         check_clocks(m, c == 2);
      end
      // Software rewrites the mask with a new random word
      m = $random(seed);
      axi_write(sclk_pkg::OFF_CLK_MASK, {16'h0, m}, sclk_pkg::RESP_OKAY);
      axi_read(sclk_pkg::OFF_CLK_MASK, {16'h0, m}, sclk_pkg::RESP_OKAY);
      check_clocks(m, 1'b0);
      // Unmapped place: refused, no data
      axi_write(8'h20, 32'hffff_ffff, sclk_pkg::RESP_SLVERR);
      axi_read(8'h20, 32'h0, sclk_pkg::RESP_SLVERR);
      // Secondary reset bit set then cleared
      axi_write(sclk_pkg::OFF_BRIDGE, 32'h1 << sclk_pkg::SEC_RST_BIT, sclk_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(secondary_reset_n, 1'b0)
      axi_write(sclk_pkg::OFF_BRIDGE, 32'h0, sclk_pkg::RESP_OKAY);
      wait_release(n);
      `CHK((n >= HOLD - 3) && (n <= HOLD + 4), 1'b1)
      // No register fitted: line tied high, then low
      boot(1'b0, 1'b1, $random(seed), 16'hffff);
      check_clocks(16'hffff, 1'b0);
      boot(1'b0, 1'b0, $random(seed), 16'h0000);
      tie_level <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_read(sclk_pkg::OFF_CLK_MASK, 32'h0, sclk_pkg::RESP_OKAY);
      check_clocks(16'h0000, 1'b0);
      finish_test();
   end
endmodule : tb_secondary_clock_mask_and_outputs
`default_nettype wire
